// file: dgp_gpio_top.sv
module dgp_gpio_top import dgp_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Register port
	input wire dgp_bus_req_t bus_req,
	output logic [7:0] reg_rdata,
	// Port D pads
	input wire logic [7:0] pd_in,
	output logic [7:0] pd_out,
	output logic [7:0] pd_oe,
	// Port E pads
	input wire logic [2:0] pe_in,
	output logic [2:0] pe_out,
	output logic [2:0] pe_oe,
	// Analog selection for the converter
	output logic [2:0] analog_sel
);

	// --------------------------------
	// State
	// --------------------------------
	logic [7:0] pd_lat_reg;
	logic [7:0] pd_dir_reg;
	logic [2:0] pe_lat_reg;
	logic [2:0] pe_dir_reg;
	logic [2:0] analog_reg;
	logic [7:0] in_buf_reg;
	logic [7:0] rdata_next;
	dgp_slave_stat_t stat_reg;
	logic [7:0] pd_drv_en;
	logic [7:0] pe_dir_view;
	logic [2:0] pe_pin_view;
	logic wr_start;
	logic rd_start;
	logic rd_sel;
	logic rd_end;
	logic hit_pd_pins;
	logic hit_pd_lat;
	logic hit_pe_pins;
	logic hit_pe_lat;
	logic hit_pd_dir;
	logic hit_pe_dir;
	logic hit_analog;
	logic pd_write;
	logic cpu_buf_read;

	// --------------------------------
	// Address decode
	// --------------------------------
	always_comb begin
		hit_pd_pins = 1'b0;
		hit_pd_lat = 1'b0;
		hit_pe_pins = 1'b0;
		hit_pe_lat = 1'b0;
		hit_pd_dir = 1'b0;
		hit_pe_dir = 1'b0;
		hit_analog = 1'b0;
		if (bus_req.addr == DGP_OFS_PD_PINS) begin
			hit_pd_pins = 1'b1;
		end else if (bus_req.addr == DGP_OFS_PD_LAT) begin
			hit_pd_lat = 1'b1;
		end else if (bus_req.addr == DGP_OFS_PE_PINS) begin
			hit_pe_pins = 1'b1;
		end else if (bus_req.addr == DGP_OFS_PE_LAT) begin
			hit_pe_lat = 1'b1;
		end else if (bus_req.addr == DGP_OFS_PD_DIR) begin
			hit_pd_dir = 1'b1;
		end else if (bus_req.addr == DGP_OFS_PE_DIR) begin
			hit_pe_dir = 1'b1;
		end else if (bus_req.addr == DGP_OFS_ANALOG) begin
			hit_analog = 1'b1;
		end
	end

	// Either port D data address writes the latch
	assign pd_write = bus_req.we & (hit_pd_pins | hit_pd_lat);
	// Core read of the pin address in slave mode takes the input buffer
	assign cpu_buf_read = bus_req.re & hit_pd_pins & stat_reg.mode;

	// --------------------------------
	// Slave port strobes
	// --------------------------------
	dgp_psp_strobe u_strobe (
		.clock(clock),
		.rst_n(rst_n),
		.enable(stat_reg.mode),
		.cs_n(pe_in[DGP_BIT_STB_CS]),
		.rd_n(pe_in[DGP_BIT_STB_RD]),
		.wr_n(pe_in[DGP_BIT_STB_WR]),
		.wr_start(wr_start),
		.rd_start(rd_start),
		.rd_sel(rd_sel),
		.rd_end(rd_end)
	);

	// --------------------------------
	// Port D latch and direction
	// --------------------------------
	// Output latch, written through either data address
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pd_lat_reg <= DGP_RST_PD_LAT;
		end else if (pd_write) begin
			pd_lat_reg <= bus_req.wdata;
		end
	end

	// Direction, all inputs after any reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pd_dir_reg <= DGP_RST_PD_DIR;
		end else if (bus_req.we && hit_pd_dir) begin
			pd_dir_reg <= bus_req.wdata;
		end
	end

	// --------------------------------
	// Port E latch, direction and analog selection
	// --------------------------------
	// Output latch
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pe_lat_reg <= DGP_RST_PE_LAT;
		end else if (bus_req.we && (hit_pe_pins || hit_pe_lat)) begin
			pe_lat_reg <= bus_req.wdata[2:0];
		end
	end

	// Direction bits, all inputs after any reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pe_dir_reg <= DGP_RST_PE_DIR;
		end else if (bus_req.we && hit_pe_dir) begin
			pe_dir_reg <= bus_req.wdata[2:0];
		end
	end

	// Analog selection, one bit per pin, 1 means analog
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			analog_reg <= DGP_RST_ANALOG;
		end else if (bus_req.we && hit_analog) begin
			analog_reg <= bus_req.wdata[2:0];
		end
	end

	// --------------------------------
	// Slave port mode and buffer flags
	// --------------------------------
	// Input buffer captures the data bus at the start of a write
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			in_buf_reg <= DGP_ZERO8;
		end else if (wr_start) begin
			in_buf_reg <= pd_in;
		end
	end

	// Mode and buffer flags in one process so the word has a single driver;
	// for every flag a set in the same cycle as its clear wins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stat_reg <= '0;
		end else begin
			// Mode bit is software owned
			if (bus_req.we && hit_pe_dir) begin
				stat_reg.mode <= bus_req.wdata[DGP_BIT_MODE];
			end
			// Input full: set by an outside write, cleared by a core read
			if (wr_start) begin
				stat_reg.input_buffer_full <= 1'b1;
			end else if (cpu_buf_read) begin
				stat_reg.input_buffer_full <= 1'b0;
			end
			// Overflow: write while full; software clears by writing 0
			if (wr_start && stat_reg.input_buffer_full) begin
				stat_reg.input_buffer_overflow <= 1'b1;
			end else if (bus_req.we && hit_pe_dir && !bus_req.wdata[DGP_BIT_INPUT_BUFFER_OVERFLOW]) begin
				stat_reg.input_buffer_overflow <= 1'b0;
			end
			// Output full: core latch write in slave mode, cleared at read end
			if (pd_write && stat_reg.mode) begin
				stat_reg.output_buffer_full <= 1'b1;
			end else if (rd_end) begin
				stat_reg.output_buffer_full <= 1'b0;
			end
		end
	end

	// --------------------------------
	// Pad drive
	// --------------------------------
	// In slave mode port D drives only while the outside reads
	always_comb begin
		if (stat_reg.mode) begin
			pd_drv_en = {8{rd_sel}};
		end else begin
			pd_drv_en = ~pd_dir_reg;
		end
	end

	dgp_pin_drv #(.W(DGP_PD_W)) u_pd_pins (
		.clock(clock),
		.rst_n(rst_n),
		.drv_en(pd_drv_en),
		.drv_val(pd_lat_reg),
		.pin_out(pd_out),
		.pin_oe(pd_oe)
	);

	// Port E direction governs drivers regardless of analog use
	dgp_pin_drv #(.W(DGP_PE_W)) u_pe_pins (
		.clock(clock),
		.rst_n(rst_n),
		.drv_en(~pe_dir_reg),
		.drv_val(pe_lat_reg),
		.pin_out(pe_out),
		.pin_oe(pe_oe)
	);

	// Analog selection leaves on a flop for the converter
	assign analog_sel = analog_reg;

	// --------------------------------
	// Read back
	// --------------------------------
	// Analog pins read as zero
	assign pe_pin_view = pe_in & ~analog_reg;
	// Status, mode, a zero bit, then the three directions
	assign pe_dir_view = {stat_reg.input_buffer_full, stat_reg.output_buffer_full, stat_reg.input_buffer_overflow,
		stat_reg.mode, 1'b0, pe_dir_reg};

	// Read mux, unmapped addresses return zero
	always_comb begin
		rdata_next = DGP_ZERO8;
		if (!bus_req.re) begin
			rdata_next = DGP_ZERO8;
		end else if (hit_pd_pins) begin
			rdata_next = stat_reg.mode ? in_buf_reg : pd_in;
		end else if (hit_pd_lat) begin
			rdata_next = pd_lat_reg;
		end else if (hit_pe_pins) begin
			rdata_next = {5'h00, pe_pin_view};
		end else if (hit_pe_lat) begin
			rdata_next = {5'h00, pe_lat_reg};
		end else if (hit_pd_dir) begin
			rdata_next = pd_dir_reg;
		end else if (hit_pe_dir) begin
			rdata_next = pe_dir_view;
		end else if (hit_analog) begin
			rdata_next = {5'h00, analog_reg};
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= DGP_ZERO8;
		end else begin
			reg_rdata <= rdata_next;
		end
	end

	// --------------------------------
	// Assertions
	// --------------------------------
	sequence s_ext_write;
		wr_start ##1 stat_reg.input_buffer_full;
	endsequence

	sequence s_ext_read_go;
		stat_reg.mode && rd_sel;
	endsequence

	a_pd_dir_reset: assert property (@(posedge clock)
		!$past(rst_n) |-> pd_oe == DGP_ZERO8 ##1 pd_dir_reg == DGP_RST_PD_DIR
		|| $past(bus_req.we))
		else $error("port D direction not all inputs after reset");

	a_pe_dir_reset: assert property (@(posedge clock)
		rst_n && !$past(rst_n) |-> pe_dir_reg == DGP_RST_PE_DIR
		&& analog_reg == DGP_RST_ANALOG && pe_dir_view[7:3] == 5'h00)
		else $error("port E control not at reset value");

	a_pd_gpio_drive: assert property (@(posedge clock) disable iff (!rst_n)
		!stat_reg.mode |=> pd_oe == ~$past(pd_dir_reg)
		&& pd_out == $past(pd_lat_reg))
		else $error("port D drive does not follow direction and latch");

	a_pe_pin_drive: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1 |=> pe_oe == ~$past(pe_dir_reg) && pe_out == $past(pe_lat_reg))
		else $error("port E drive does not follow direction and latch");

	a_pd_lat_read: assert property (@(posedge clock) disable iff (!rst_n)
		bus_req.re && hit_pd_lat |=> reg_rdata == $past(pd_lat_reg))
		else $error("port D latch read does not return latch");

	a_pe_lat_read: assert property (@(posedge clock) disable iff (!rst_n)
		bus_req.re && hit_pe_lat |=> reg_rdata == {5'h00, $past(pe_lat_reg)})
		else $error("port E latch read does not return latch");

	a_pe_analog_zero: assert property (@(posedge clock) disable iff (!rst_n)
		bus_req.re && hit_pe_pins |=> (reg_rdata[2:0] & $past(analog_reg)) == 3'h0
		&& reg_rdata[7:3] == 5'h00)
		else $error("analog pin read back non-zero");

	a_pe_unimp_zero: assert property (@(posedge clock) disable iff (!rst_n)
		bus_req.re && hit_pe_dir |=> reg_rdata[DGP_BIT_UNIMP] == 1'b0
		&& reg_rdata[DGP_BIT_MODE] == $past(stat_reg.mode))
		else $error("port E control read layout wrong");

	a_psp_write_capture: assert property (@(posedge clock) disable iff (!rst_n)
		s_ext_write |-> in_buf_reg == $past(pd_in))
		else $error("slave write did not capture data");

	a_psp_read_drive: assert property (@(posedge clock) disable iff (!rst_n)
		s_ext_read_go |=> pd_oe == 8'hFF && pd_out == $past(pd_lat_reg))
		else $error("slave read does not drive latch on port D");

	a_psp_overflow: assert property (@(posedge clock) disable iff (!rst_n)
		wr_start && stat_reg.input_buffer_full |=> stat_reg.input_buffer_overflow && stat_reg.input_buffer_full)
		else $error("overflow not flagged on write while full");

	a_psp_idle_float: assert property (@(posedge clock) disable iff (!rst_n)
		stat_reg.mode && !rd_sel ##1 stat_reg.mode |-> pd_oe == DGP_ZERO8)
		else $error("port D driven in slave mode without read");

	a_psp_read_start: assert property (@(posedge clock) disable iff (!rst_n)
		rd_start |=> pd_oe == 8'hFF)
		else $error("slave read start did not turn port D around");

endmodule

// file: dgp_pkg.sv
package dgp_pkg;

	// --------------------------------
	// Widths
	// --------------------------------
	localparam int DGP_DATA_W = 8;
	localparam int DGP_ADDR_W = 4;
	localparam int DGP_PD_W = 8;
	localparam int DGP_PE_W = 3;

	// --------------------------------
	// Register offsets
	// --------------------------------
	localparam logic [3:0] DGP_OFS_PD_PINS = 4'h0;
	localparam logic [3:0] DGP_OFS_PE_PINS = 4'h1;
	localparam logic [3:0] DGP_OFS_PD_LAT = 4'h2;
	localparam logic [3:0] DGP_OFS_PE_LAT = 4'h3;
	localparam logic [3:0] DGP_OFS_PD_DIR = 4'h4;
	localparam logic [3:0] DGP_OFS_PE_DIR = 4'h5;
	localparam logic [3:0] DGP_OFS_ANALOG = 4'h6;

	// --------------------------------
	// Field positions of the port E direction and slave control register
	// --------------------------------
	localparam int DGP_BIT_IBF = 7;
	localparam int DGP_BIT_OBF = 6;
	localparam int DGP_BIT_INPUT_BUFFER_OVERFLOW = 5;
	localparam int DGP_BIT_MODE = 4;
	localparam int DGP_BIT_UNIMP = 3;
	localparam int DGP_BIT_STB_RD = 0;
	localparam int DGP_BIT_STB_WR = 1;
	localparam int DGP_BIT_STB_CS = 2;

	// --------------------------------
	// Reset values
	// --------------------------------
	localparam logic [7:0] DGP_RST_PD_DIR = 8'hFF;
	localparam logic [2:0] DGP_RST_PE_DIR = 3'h7;
	localparam logic [7:0] DGP_RST_PD_LAT = 8'h00;
	localparam logic [2:0] DGP_RST_PE_LAT = 3'h0;
	localparam logic [2:0] DGP_RST_ANALOG = 3'h7;
	localparam logic [7:0] DGP_ZERO8 = 8'h00;

	// --------------------------------
	// Carriers
	// --------------------------------
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} dgp_bus_req_t;

	typedef struct packed {
		logic input_buffer_full;
		logic output_buffer_full;
		logic input_buffer_overflow;
		logic mode;
	} dgp_slave_stat_t;

endpackage

// file: dgp_pin_drv.sv
// Registered pad driver: output value and enable leave from flip-flops
module dgp_pin_drv import dgp_pkg::*; #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Drive request
	input wire logic [W-1:0] drv_en,
	input wire logic [W-1:0] drv_val,
	// Pad side
	output logic [W-1:0] pin_out,
	output logic [W-1:0] pin_oe
);

	// Enables start low so no pin is driven out of reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_oe <= '0;
			pin_out <= '0;
		end else begin
			pin_oe <= drv_en;
			pin_out <= drv_val;
		end
	end

endmodule

// file: dgp_psp_strobe.sv
// Edge finder for the active-low slave port strobes
module dgp_psp_strobe import dgp_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Strobe levels
	input wire logic enable,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	// Events
	output logic wr_start,
	output logic rd_start,
	output logic rd_sel,
	output logic rd_end
);

	logic wr_sel;
	logic wr_sel_reg;
	logic rd_sel_reg;

	// Selected means enable high with chip select and the strobe both low
	assign wr_sel = enable & ~cs_n & ~wr_n;
	assign rd_sel = enable & ~cs_n & ~rd_n;

	// Previous levels for first-detection edges
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_sel_reg <= 1'b0;
			rd_sel_reg <= 1'b0;
		end else begin
			wr_sel_reg <= wr_sel;
			rd_sel_reg <= rd_sel;
		end
	end

	// Starts fire on the first cycle both lines are low
	assign wr_start = wr_sel & ~wr_sel_reg;
	assign rd_start = rd_sel & ~rd_sel_reg;
	assign rd_end = rd_sel_reg & ~rd_sel;

endmodule

// file: tb_top.sv
module tb_top import dgp_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	// --------------------------------
	// Signals
	// --------------------------------
	logic clock;
	logic rst_n;
	dgp_bus_req_t bus_req;
	logic [7:0] reg_rdata;
	logic [7:0] pd_in;
	logic [7:0] pd_out;
	logic [7:0] pd_oe;
	logic [2:0] pe_in;
	logic [2:0] pe_out;
	logic [2:0] pe_oe;
	logic [2:0] analog_sel;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	logic [7:0] dirs [5] = '{8'h00, 8'hCF, 8'hA5, 8'h5A, 8'hFF};

	// --------------------------------
	// Device under test
	// --------------------------------
	dgp_gpio_top DUT (
		.clock(clock),
		.rst_n(rst_n),
		.bus_req(bus_req),
		.reg_rdata(reg_rdata),
		.pd_in(pd_in),
		.pd_out(pd_out),
		.pd_oe(pd_oe),
		.pe_in(pe_in),
		.pe_out(pe_out),
		.pe_oe(pe_oe),
		.analog_sel(analog_sel)
	);

	// Clock of 20 ns period
	initial clock = 1'b0;
	always #10 clock = ~clock;

	// Cut a hang short well beyond the expected run length
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			conclude();
		end
	end

	// --------------------------------
	// Tasks
	// --------------------------------
	// Compare one value and count it
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One-cycle register write
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clock);
		bus_req.we <= 1'b0;
	endtask

	// One-cycle register read, data checked in the following cycle only
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge clock);
		bus_req.re <= 1'b0;
		@(negedge clock);
		check(reg_rdata, exp);
	endtask

	// Let register changes reach the pads
	task automatic settle();
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask

	// Hold outside strobes low for one transfer
	task automatic strobe(input logic [2:0] pe, input logic [7:0] pd);
		@(posedge clock);
		pe_in <= pe;
		pd_in <= pd;
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask

	// Return all strobes to idle high
	task automatic unstrobe();
		@(posedge clock);
		pe_in <= 3'h7;
		repeat (2) @(posedge clock);
	endtask

	// Print counts and verdict, then stop
	task automatic conclude();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		rst_n = 1'b0;
		bus_req = '0;
		pd_in = 8'h00;
		pe_in = 3'h7;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		// Reset state
		rd(DGP_OFS_PD_DIR, 8'hFF);
		rd(DGP_OFS_PE_DIR, 8'h07);
		check({5'h00, analog_sel}, 8'h07);
		check(pd_oe, 8'h00);
		check({5'h00, pe_oe}, 8'h00);
		// Direction patterns on port D
		wr(DGP_OFS_PD_LAT, 8'h5A);
		foreach (dirs[i]) begin
			wr(DGP_OFS_PD_DIR, dirs[i]);
			settle();
			check(pd_oe, ~dirs[i]);
			check(pd_out & pd_oe, 8'h5A & ~dirs[i]);
			rd(DGP_OFS_PD_DIR, dirs[i]);
		end
		// Latch read back against pin levels
		@(posedge clock);
		pd_in <= 8'h33;
		rd(DGP_OFS_PD_LAT, 8'h5A);
		rd(DGP_OFS_PD_PINS, 8'h33);
		wr(DGP_OFS_PD_PINS, 8'hC3);
		rd(DGP_OFS_PD_LAT, 8'hC3);
		// Port E drive beside an analog pin that stays an input
		wr(DGP_OFS_PE_LAT, 8'h05);
		rd(DGP_OFS_PE_PINS, 8'h00);
		wr(DGP_OFS_ANALOG, 8'h02);
		wr(DGP_OFS_PE_DIR, 8'hEA);
		rd(DGP_OFS_PE_DIR, 8'h02);
		settle();
		check({5'h00, pe_oe}, 8'h05);
		check({5'h00, pe_out & pe_oe}, 8'h05);
		check({5'h00, analog_sel}, 8'h02);
		rd(DGP_OFS_PE_PINS, 8'h05);
		rd(DGP_OFS_PE_LAT, 8'h05);
		// Enter slave mode only once the strobe pins are digital inputs
		wr(DGP_OFS_PD_LAT, 8'h96);
		wr(DGP_OFS_ANALOG, 8'h00);
		wr(DGP_OFS_PE_DIR, 8'h07);
		wr(DGP_OFS_PE_DIR, 8'h17);
		rd(DGP_OFS_PE_DIR, 8'h17);
		// Outside write held low for several cycles is one transfer
		strobe(3'b001, 8'hAB);
		unstrobe();
		rd(DGP_OFS_PE_DIR, 8'h97);
		rd(DGP_OFS_PD_PINS, 8'hAB);
		rd(DGP_OFS_PE_DIR, 8'h17);
		// Two writes without a core read flag the overflow
		strobe(3'b001, 8'h11);
		unstrobe();
		strobe(3'b001, 8'h22);
		unstrobe();
		rd(DGP_OFS_PE_DIR, 8'hB7);
		rd(DGP_OFS_PD_PINS, 8'h22);
		wr(DGP_OFS_PE_DIR, 8'h17);
		rd(DGP_OFS_PE_DIR, 8'h17);
		// Core write fills the output buffer, outside read empties it
		wr(DGP_OFS_PD_LAT, 8'h96);
		rd(DGP_OFS_PE_DIR, 8'h57);
		strobe(3'b010, 8'h00);
		check(pd_oe, 8'hFF);
		check(pd_out, 8'h96);
		unstrobe();
		rd(DGP_OFS_PE_DIR, 8'h17);
		settle();
		check(pd_oe, 8'h00);
		// Strobes have no effect outside slave mode
		wr(DGP_OFS_PE_DIR, 8'h07);
		strobe(3'b001, 8'h55);
		unstrobe();
		rd(DGP_OFS_PE_DIR, 8'h07);
		// Second reset in mid-run
		wr(DGP_OFS_PD_DIR, 8'h00);
		wr(DGP_OFS_PE_DIR, 8'h00);
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		rd(DGP_OFS_PD_DIR, 8'hFF);
		rd(DGP_OFS_PE_DIR, 8'h07);
		check({5'h00, analog_sel}, 8'h07);
		check(pd_oe, 8'h00);
		check({5'h00, pe_oe}, 8'h00);
		conclude();
	end
endmodule
